/* pcaa_array.sv */
// Counter array with six capture/compare modules behind a plain register port.
`timescale 1ns/10ps

module pcaa_array
  import pcaa_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_timer0_ovf,
  input wire logic i_ext_count_input,
  input wire logic i_ext_osc,
  input wire logic i_cpu_idle,
  input wire logic i_rmw_ctrl,
  input wire logic [NUM_MODULES-1:0] i_module_line,
  output logic [NUM_MODULES-1:0] o_module_line,
  output logic [NUM_MODULES-1:0] o_module_line_oe_n,
  output logic o_irq
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (NUM_MODULES < 1 || NUM_MODULES > 6) begin : g_bad_count
    $error("module count must be 1 to 6");
  end

  pcaa_state_type st_r;
  pcaa_state_type st_nxt;
  logic tick;
  logic inc;
  logic [15:0] cnt_inc;
  logic [NUM_MODULES-1:0] cap_evt;
  logic [NUM_MODULES-1:0] hit16;
  logic pwm8_mode;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic eci_fall;
    logic osc_rise;
    logic low_wrap;
    logic [7:0] mm;
    logic hit8;
    logic rise;
    logic fall;
    logic [7:0] midx;
    eci_fall = 1'b0;
    osc_rise = 1'b0;
    low_wrap = 1'b0;
    mm = RST_BYTE;
    hit8 = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    midx = RST_BYTE;
    st_nxt = st_r;
    cap_evt = '0;
    hit16 = '0;

    // External inputs pass three flops; a level counts once flops two and three agree.
    st_nxt.eci_sync = {st_r.eci_sync[1:0], i_ext_count_input};
    if (st_r.eci_sync[1] == st_r.eci_sync[2]) begin
      st_nxt.eci_filt = st_r.eci_sync[2];
    end
    eci_fall = st_r.eci_filt && !st_nxt.eci_filt;
    st_nxt.osc_sync = {st_r.osc_sync[1:0], i_ext_osc};
    if (st_r.osc_sync[1] == st_r.osc_sync[2]) begin
      st_nxt.osc_filt = st_r.osc_sync[2];
    end
    osc_rise = !st_r.osc_filt && st_nxt.osc_filt;

    // Prescaler for the divided system clock and the divided oscillator.
    st_nxt.presc = (st_r.presc == DIV12_LAST) ? 4'h0 : st_r.presc + 4'h1;
    if (osc_rise) begin
      st_nxt.osc_div = st_r.osc_div + 3'h1;
    end

    // Timebase select.
    case (st_r.tbsel)
      TB_DIV12: tick = (st_r.presc == DIV12_LAST);
      TB_DIV4: tick = (st_r.presc[1:0] == DIV4_LAST);
      TB_T0OVF: tick = i_timer0_ovf;
      TB_EXTIN: tick = eci_fall;
      TB_SYS: tick = 1'b1;
      TB_OSC8: tick = osc_rise && (st_r.osc_div == OSC_DIV_LAST);
      default: tick = 1'b0;
    endcase

    // Count while running, unless stopped by idle with the stop bit set.
    inc = st_r.run && tick && !(i_cpu_idle && st_r.idle_stop);
    cnt_inc = st_r.cnt + 16'h1;
    if (inc) begin
      st_nxt.cnt = cnt_inc;
    end
    low_wrap = inc && (st_r.cnt[7:0] == 8'hff);

    // Register writes; hardware sets below win over the cleared value.
    if (i_wr) begin
      if (i_addr == OFF_CTRL) begin
        st_nxt.ovf = i_wdata[CTRL_OVF_BIT];
        st_nxt.run = i_wdata[CTRL_RUN_BIT];
        st_nxt.mflag = i_wdata[NUM_MODULES-1:0];
      end else if (i_addr == OFF_MODE) begin
        st_nxt.idle_stop = i_wdata[MODE_IDLE_BIT];
        st_nxt.tbsel = i_wdata[MODE_TB_LSB+:3];
        st_nxt.ovf_ie = i_wdata[MODE_OVF_IE_BIT];
      end else if (i_addr == OFF_CNT_LO) begin
        st_nxt.cnt[7:0] = i_wdata;
      end else if (i_addr == OFF_CNT_HI) begin
        st_nxt.cnt[15:8] = i_wdata;
      end else if (i_addr == OFF_IRQ_EN) begin
        st_nxt.gie = i_wdata[IRQ_GLOBAL_BIT];
        st_nxt.aie = i_wdata[IRQ_ARRAY_BIT];
      end else if (i_addr >= OFF_MMODE_BASE && i_addr < OFF_MMODE_BASE + 8'(NUM_MODULES)) begin
        midx = i_addr - OFF_MMODE_BASE;
        st_nxt.mmode[midx[2:0]] = i_wdata;
      end else if (i_addr >= OFF_VLO_BASE && i_addr < OFF_VLO_BASE + 8'(NUM_MODULES)) begin
        midx = i_addr - OFF_VLO_BASE;
        st_nxt.vlo[midx[2:0]] = i_wdata;
      end else if (i_addr >= OFF_VHI_BASE && i_addr < OFF_VHI_BASE + 8'(NUM_MODULES)) begin
        midx = i_addr - OFF_VHI_BASE;
        st_nxt.vhi[midx[2:0]] = i_wdata;
      end
    end

    // Overflow sets the flag unless a read-modify-write of the control register is running.
    if (inc && st_r.cnt == 16'hffff && !i_rmw_ctrl) begin
      st_nxt.ovf = 1'b1;
    end

    // Per-module behaviour.
    for (int k = 0; k < NUM_MODULES; k++) begin
      mm = st_r.mmode[k];
      // Line filter: three flops, level valid after two equal samples.
      st_nxt.line_sync[k] = {st_r.line_sync[k][1:0], i_module_line[k]};
      if (st_r.line_sync[k][1] == st_r.line_sync[k][2]) begin
        st_nxt.line_filt[k] = st_r.line_sync[k][2];
      end
      rise = !st_r.line_filt[k] && st_nxt.line_filt[k];
      fall = st_r.line_filt[k] && !st_nxt.line_filt[k];
      hit16[k] = inc && (cnt_inc == {st_r.vhi[k], st_r.vlo[k]});
      hit8 = inc && (cnt_inc[7:0] == st_r.vlo[k]);
      // Output modes drive the line; capture modes leave it as an input.
      st_nxt.line_oe_n[k] = !(mm[MM_CMP] && (mm[MM_TOG] || mm[MM_PWM]));
      if (!mm[MM_MAT] && !mm[MM_TOG] && !mm[MM_PWM] && (mm[MM_RISE] || mm[MM_FALL])) begin
        // Edge-triggered capture.
        cap_evt[k] = (mm[MM_RISE] && rise) || (mm[MM_FALL] && fall);
        if (cap_evt[k]) begin
          st_nxt.vlo[k] = st_r.cnt[7:0];
          st_nxt.vhi[k] = st_r.cnt[15:8];
          st_nxt.mflag[k] = 1'b1;
        end
      end else if (mm[MM_CMP] && mm[MM_MAT] && !mm[MM_PWM]) begin
        // Software timer, with toggle for high-speed output.
        if (hit16[k]) begin
          st_nxt.mflag[k] = 1'b1;
          if (mm[MM_TOG]) begin
            st_nxt.line_out[k] = !st_r.line_out[k];
          end
        end
      end else if (mm[MM_CMP] && mm[MM_TOG] && mm[MM_PWM]) begin
        // Frequency output; adding a zero high byte wraps a full 256 counts.
        if (hit8) begin
          st_nxt.line_out[k] = !st_r.line_out[k];
          st_nxt.vlo[k] = st_r.vlo[k] + st_r.vhi[k];
        end
      end else if (mm[MM_CMP] && mm[MM_PWM] && !mm[MM_WIDE]) begin
        // 8-bit PWM: a match at the wrap itself keeps the line high.
        if (low_wrap) begin
          st_nxt.line_out[k] = 1'b0;
          st_nxt.vlo[k] = st_r.vhi[k];
        end
        if (hit8) begin
          st_nxt.line_out[k] = 1'b1;
        end
      end else if (mm[MM_CMP] && mm[MM_PWM] && mm[MM_WIDE]) begin
        // 16-bit PWM with a match flag for duty updates.
        if (inc && st_r.cnt == 16'hffff) begin
          st_nxt.line_out[k] = 1'b0;
        end
        if (hit16[k]) begin
          st_nxt.line_out[k] = 1'b1;
          st_nxt.mflag[k] = 1'b1;
        end
      end
    end

    // Read data, valid one cycle after the strobe; unmapped offsets read zero.
    st_nxt.rdata = RST_BYTE;
    if (i_rd) begin
      if (i_addr == OFF_CTRL) begin
        st_nxt.rdata = {st_r.ovf, st_r.run, 6'(st_r.mflag)};
      end else if (i_addr == OFF_MODE) begin
        st_nxt.rdata = {st_r.idle_stop, 3'h0, st_r.tbsel, st_r.ovf_ie};
      end else if (i_addr == OFF_CNT_LO) begin
        st_nxt.rdata = st_r.cnt[7:0];
        st_nxt.snap = st_r.cnt[15:8];
      end else if (i_addr == OFF_CNT_HI) begin
        st_nxt.rdata = st_r.snap;
      end else if (i_addr == OFF_IRQ_EN) begin
        st_nxt.rdata = {6'h00, st_r.aie, st_r.gie};
      end else if (i_addr >= OFF_MMODE_BASE && i_addr < OFF_MMODE_BASE + 8'(NUM_MODULES)) begin
        midx = i_addr - OFF_MMODE_BASE;
        st_nxt.rdata = st_r.mmode[midx[2:0]];
      end else if (i_addr >= OFF_VLO_BASE && i_addr < OFF_VLO_BASE + 8'(NUM_MODULES)) begin
        midx = i_addr - OFF_VLO_BASE;
        st_nxt.rdata = st_r.vlo[midx[2:0]];
      end else if (i_addr >= OFF_VHI_BASE && i_addr < OFF_VHI_BASE + 8'(NUM_MODULES)) begin
        midx = i_addr - OFF_VHI_BASE;
        st_nxt.rdata = st_r.vhi[midx[2:0]];
      end
    end

    // Interrupt request from the registered flags and enables.
    st_nxt.irq = st_r.gie && st_r.aie &&
                 ((st_r.ovf && st_r.ovf_ie) || |(st_r.mflag & mie(st_r.mmode)));
  end

  // Collects the per-module interrupt enable bits.
  function automatic logic [NUM_MODULES-1:0] mie(input logic [NUM_MODULES-1:0][7:0] modes);
    logic [NUM_MODULES-1:0] res;
    res = '0;
    for (int j = 0; j < NUM_MODULES; j++) begin
      res[j] = modes[j][MM_IE];
    end
    return res;
  endfunction

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= '0;
      st_r.line_oe_n <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flops.
  assign o_rdata = st_r.rdata;
  assign o_module_line = st_r.line_out;
  assign o_module_line_oe_n = st_r.line_oe_n;
  assign o_irq = st_r.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_rd_lo;
    i_rd && i_addr == OFF_CNT_LO;
  endsequence

  sequence s_rd_hi;
    i_rd && i_addr == OFF_CNT_HI;
  endsequence

  snapshot_read_a: assert property (s_rd_lo ##1 s_rd_hi |=> o_rdata == $past(st_r.cnt[15:8], 2))
    else $error("high byte read does not return the latched copy");

  count_undisturbed_a: assert property ((!(i_wr && (i_addr == OFF_CNT_LO || i_addr == OFF_CNT_HI)))
    |=> (st_r.cnt == $past(st_r.cnt) || st_r.cnt == $past(st_r.cnt) + 16'h1))
    else $error("counter moved other than by one");

  sys_timebase_a: assert property ((st_r.tbsel == TB_SYS && st_r.run && !i_cpu_idle) |-> inc)
    else $error("system clock timebase missed a count");

  idle_keeps_a: assert property ((i_cpu_idle && !st_r.idle_stop && st_r.run && tick) |-> inc)
    else $error("counter stopped in idle with stop bit clear");

  ovf_set_a: assert property ((inc && st_r.cnt == 16'hffff && !i_rmw_ctrl) |=> st_r.ovf)
    else $error("overflow flag not set on wrap");

  rmw_mask_a: assert property ((inc && st_r.cnt == 16'hffff && i_rmw_ctrl && !st_r.ovf && !i_wr)
    |=> !st_r.ovf)
    else $error("overflow set during control read-modify-write");

  irq_gate_a: assert property (o_irq |-> $past(st_r.gie) && $past(st_r.aie))
    else $error("interrupt raised without both enables");

  capture_load_a: assert property (cap_evt[0] |=> {st_r.vhi[0], st_r.vlo[0]} == $past(st_r.cnt)
    && st_r.mflag[0])
    else $error("capture did not load counter and flag");

  hso_toggle_a: assert property ((hit16[2] && st_r.mmode[2][MM_CMP] && st_r.mmode[2][MM_MAT]
    && st_r.mmode[2][MM_TOG] && !st_r.mmode[2][MM_PWM]) |=> o_module_line[2] != $past(o_module_line[2]))
    else $error("high-speed output did not toggle on match");

  // Read data falls back to zero after any cycle without a read strobe.
  rdata_quiet_a: assert property (!i_rd |=> o_rdata == RST_BYTE)
    else $error("read data not zero outside a read answer");

  // Flags stay set until software writes the control register.
  ovf_sticky_a: assert property ((st_r.ovf && !(i_wr && i_addr == OFF_CTRL)) |=> st_r.ovf)
    else $error("overflow flag cleared without a write");

  flag_sticky_a: assert property ((st_r.mflag[0] && !(i_wr && i_addr == OFF_CTRL)) |=> st_r.mflag[0])
    else $error("module flag cleared without a write");

  // With the stop bit set the counter halts while the processor idles.
  idle_stop_a: assert property ((i_cpu_idle && st_r.idle_stop) |-> !inc)
    else $error("counter advanced in idle with stop bit set");

  // A pending overflow with every enable set raises the request one cycle later.
  irq_raise_a: assert property ((st_r.gie && st_r.aie && st_r.ovf && st_r.ovf_ie) |=> o_irq)
    else $error("enabled overflow raised no interrupt");

  // Module 1 as a software timer flags its match.
  timer_flag_a: assert property ((hit16[1] && st_r.mmode[1][MM_CMP] && st_r.mmode[1][MM_MAT]
    && !st_r.mmode[1][MM_PWM]) |=> st_r.mflag[1])
    else $error("timer match did not set the module flag");

  // Module 0 as a 16-bit modulator goes high on a full match.
  wide_pwm_select_high_a: assert property ((hit16[0] && st_r.mmode[0][MM_WIDE] && st_r.mmode[0][MM_CMP]
    && st_r.mmode[0][MM_PWM] && !st_r.mmode[0][MM_TOG]) |=> o_module_line[0])
    else $error("16-bit PWM line not high after match");

  // Module 2 in an output mode drives its line.
  line_drive_a: assert property ((st_r.mmode[2][MM_CMP] && st_r.mmode[2][MM_TOG]) |=> !o_module_line_oe_n[2])
    else $error("output mode left the line undriven");

  // Module 3 in frequency mode: a low-byte match toggles the line and steps the compare value.
  sequence s_freq_hit;
    inc && cnt_inc[7:0] == st_r.vlo[3] && st_r.mmode[3][MM_CMP] && st_r.mmode[3][MM_TOG]
      && st_r.mmode[3][MM_PWM];
  endsequence

  sequence s_freq_step;
    st_r.vlo[3] == $past(st_r.vlo[3]) + $past(st_r.vhi[3]) && o_module_line[3] != $past(o_module_line[3]);
  endsequence

  freq_step_a: assert property (s_freq_hit |=> s_freq_step)
    else $error("frequency output did not toggle and step");

  // Module 5 in 8-bit mode: high on a low-byte match, low and reloaded on a low-byte wrap.
  assign pwm8_mode = st_r.mmode[5][MM_CMP] && st_r.mmode[5][MM_PWM] && !st_r.mmode[5][MM_WIDE]
    && !st_r.mmode[5][MM_TOG];

  sequence s_pwm8_wrap;
    pwm8_mode && inc && st_r.cnt[7:0] == 8'hff && st_r.vlo[5] != 8'h00;
  endsequence

  sequence s_pwm8_match;
    pwm8_mode && inc && cnt_inc[7:0] == st_r.vlo[5];
  endsequence

  pwm8_reload_a: assert property (s_pwm8_wrap |=> st_r.vlo[5] == $past(st_r.vhi[5]) && !o_module_line[5])
    else $error("8-bit PWM did not reload and drop at wrap");

  pwm8_high_a: assert property (s_pwm8_match |=> o_module_line[5])
    else $error("8-bit PWM line not high after match");

endmodule

/* pcaa_pkg.sv */
// Package for the counter array: register map, field positions, codes and counts.
package pcaa_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_MODULES = 6;
  localparam int HOLD_CYCLES = 2;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] OSC_DIV_LAST = 3'h7;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h01;
  localparam logic [7:0] OFF_CNT_LO = 8'h02;
  localparam logic [7:0] OFF_CNT_HI = 8'h03;
  localparam logic [7:0] OFF_IRQ_EN = 8'h04;
  localparam logic [7:0] OFF_MMODE_BASE = 8'h10;
  localparam logic [7:0] OFF_VLO_BASE = 8'h18;
  localparam logic [7:0] OFF_VHI_BASE = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_TB_LSB = 1;
  localparam int MODE_OVF_IE_BIT = 0;
  localparam int IRQ_GLOBAL_BIT = 0;
  localparam int IRQ_ARRAY_BIT = 1;
  localparam int MM_WIDE = 7;
  localparam int MM_CMP = 6;
  localparam int MM_RISE = 5;
  localparam int MM_FALL = 4;
  localparam int MM_MAT = 3;
  localparam int MM_TOG = 2;
  localparam int MM_PWM = 1;
  localparam int MM_IE = 0;

  // ****************************************************************
  // Timebase codes and reset values
  // ****************************************************************
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_T0OVF = 3'h2;
  localparam logic [2:0] TB_EXTIN = 3'h3;
  localparam logic [2:0] TB_SYS = 3'h4;
  localparam logic [2:0] TB_OSC8 = 3'h5;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Whole state of the array.
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] snap;
    logic [3:0] presc;
    logic [2:0] osc_div;
    logic [2:0] eci_sync;
    logic eci_filt;
    logic [2:0] osc_sync;
    logic osc_filt;
    logic [NUM_MODULES-1:0][2:0] line_sync;
    logic [NUM_MODULES-1:0] line_filt;
    logic ovf;
    logic run;
    logic [NUM_MODULES-1:0] mflag;
    logic idle_stop;
    logic [2:0] tbsel;
    logic ovf_ie;
    logic gie;
    logic aie;
    logic [NUM_MODULES-1:0][7:0] mmode;
    logic [NUM_MODULES-1:0][7:0] vlo;
    logic [NUM_MODULES-1:0][7:0] vhi;
    logic [NUM_MODULES-1:0] line_out;
    logic [NUM_MODULES-1:0] line_oe_n;
    logic [7:0] rdata;
    logic irq;
  } pcaa_state_type;

endpackage

/* pcaa_partner.sv */
// Behavioural model of the pins that surround the counter array.
`timescale 1ns/10ps
module pcaa_partner (
  input wire logic i_clk,
  input wire logic [5:0] i_level,
  output logic o_timer0_ovf,
  output logic o_ext_count_input,
  output logic o_ext_osc,
  output logic [5:0] o_module_line
);
  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic [3:0] t0_r;

  // Every source starts from a known level.
  initial begin
    t0_r = 4'h0;
    o_timer0_ovf = 1'b0;
    o_ext_count_input = 1'b1;
    o_ext_osc = 1'b0;
    o_module_line = 6'h00;
  end

  // Free-running oscillator with a 24 ns period, toggling on falling clock edges.
  always #12 o_ext_osc = ~o_ext_osc;

  // Count input falls every 32 ns, well under a quarter of the clock rate.
  always #16 o_ext_count_input = ~o_ext_count_input;

  // Timer 0 overflow pulses for one cycle in every sixteen.
  always @(posedge i_clk) begin
    t0_r <= t0_r + 4'h1;
    o_timer0_ovf <= (t0_r == 4'hf);
  end

  // Line levels follow the request and are held as long as it is held.
  always @(posedge i_clk) begin
    o_module_line <= i_level;
  end
endmodule

/* tb_pcaa_capture_compare_array.sv */
// Self-checking bench for the counter array.
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin fail_count++; $display("BAD %s exp %h got %h", n, e, s); end end
module tb_pca_capture_compare_array
  import pcaa_pkg::*;
;
  // ****************************************************************
  // Signals and clock
  // ****************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic idle = 1'b0;
  logic rmw = 1'b0;
  logic [NUM_MODULES-1:0] line_req = 6'h00;
  logic [NUM_MODULES-1:0] drv_line;
  logic [NUM_MODULES-1:0] dut_line;
  logic [NUM_MODULES-1:0] oe_n;
  logic [NUM_MODULES-1:0] line_w;
  logic [7:0] rdata;
  logic irq;
  logic t0;
  logic ext_count_input;
  logic osc;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'hc1694151;
  logic [7:0] d;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [7:0] ctl;
  logic [7:0] cm;
  logic [15:0] c;
  int e;
  int tol;
  logic [7:0] capt [3] = '{8'h20, 8'h10, 8'h30};
  logic [7:0] mm [6] = '{8'hc2, 8'h49, 8'h4c, 8'h46, 8'h46, 8'h42};
  logic [7:0] vl [6] = '{8'h00, 8'h10, 8'h20, 8'h10, 8'h05, 8'h80};
  logic [7:0] vh [6] = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h40};

  // The clock toggles every 2 ns for a 250 MHz rate.
  always #2 clk = ~clk;

  // A line that the array does not drive carries the model's level.
  assign line_w = (drv_line & oe_n) | (dut_line & ~oe_n);

  pcaa_array DUT (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_timer0_ovf(t0), .i_ext_count_input(ext_count_input), .i_ext_osc(osc), .i_cpu_idle(idle),
    .i_rmw_ctrl(rmw), .i_module_line(line_w), .o_module_line(dut_line), .o_module_line_oe_n(oe_n),
    .o_irq(irq));

  pcaa_partner PARTNER (.i_clk(clk), .i_level(line_req), .o_timer0_ovf(t0), .o_ext_count_input(ext_count_input),
    .o_ext_osc(osc), .o_module_line(drv_line));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected ticks in a 240-cycle run for each timebase code.
  function automatic int tb_exp(input int k);
    case (k)
      0: return 20;
      1: return 60;
      2: return 15;
      3: return 30;
      4: return 240;
      5: return 5;
      default: return 0;
    endcase
  endfunction

  // Walks the frequency output from count 1 to n: toggle level and low byte.
  function automatic logic [8:0] frq(input int n, input logic [7:0] s, input logic [7:0] st);
    logic [7:0] v;
    logic t;
    v = s;
    t = 1'b0;
    for (int i = 1; i <= n; i++) begin
      if (i[7:0] == v) begin
        t = ~t;
        v = v + st;
      end
    end
    return {t, v};
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic set_cnt(input logic [15:0] v);
    wr_reg(OFF_CNT_LO, v[7:0]);
    wr_reg(OFF_CNT_HI, v[15:8]);
  endtask

  // Reads the low byte and then the high byte with back-to-back strobes.
  task automatic rd_cnt(output logic [15:0] v);
    @(posedge clk);
    addr <= OFF_CNT_LO;
    rd <= 1'b1;
    @(posedge clk);
    addr <= OFF_CNT_HI;
    #1;
    v[7:0] = rdata;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v[15:8] = rdata;
  endtask

  // Runs the counter for about n cycles, keeps the flags seen, then stops it.
  task automatic run_for(input int n);
    wr_reg(OFF_CTRL, 8'h40);
    repeat (n - 4) @(posedge clk);
    rd_reg(OFF_CTRL, ctl);
    wr_reg(OFF_CTRL, 8'h00);
  endtask

  // Compares every compare-mode output against the stopped count.
  task automatic chk_out(input logic tf);
    logic [8:0] f3;
    logic [8:0] f4;
    rd_cnt(c);
    f3 = frq(int'(c), 8'h10, 8'h08);
    f4 = frq(int'(c), 8'h05, 8'h00);
    `CHK("timer flag", tf, ctl[1])
    `CHK("hso line", c >= 16'h0020, dut_line[2])
    rd_reg(8'h1b, d);
    `CHK("freq low", f3[7:0], d)
    `CHK("freq line", f3[8], dut_line[3])
    rd_reg(8'h1c, d);
    `CHK("freq256 low", f4[7:0], d)
    `CHK("freq256 line", f4[8], dut_line[4])
    rd_reg(8'h1d, d);
    `CHK("pwm8 reload", (c >= 16'h0100) ? 8'h40 : 8'h80, d)
    `CHK("pwm8 line", (c >= 16'h0100) ? (c[7:0] >= 8'h40) : (c[7:0] >= 8'h80), dut_line[5])
    `CHK("wide_pwm_select line", c >= 16'h0100, dut_line[0])
    `CHK("drive enables", 6'h02, oe_n)
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    `CHK("reset drive", 6'h3f, oe_n)
    wr_reg(8'h30, 8'hff);
    for (int a = 0; a < 6; a++) begin
      rd_reg((a == 5) ? 8'h30 : a[7:0], d);
      `CHK("reset reg", 8'h00, d)
    end
    // The low-byte read freezes the high byte until it is read.
    seed = lfsr(seed);
    set_cnt(seed[15:0]);
    rd_reg(OFF_CNT_LO, d);
    `CHK("count low", seed[7:0], d)
    wr_reg(OFF_CNT_HI, ~seed[15:8]);
    rd_reg(OFF_CNT_HI, d);
    `CHK("held high", seed[15:8], d)
    rd_cnt(c);
    `CHK("count intact", {~seed[15:8], seed[7:0]}, c)
    // Every timebase code, half of them in idle; a last pass stops the system clock count by idle.
    for (int k = 0; k < 9; k++) begin
      idle <= k[0] || k == 8;
      set_cnt(16'h0000);
      wr_reg(OFF_MODE, {k == 8, 3'h0, (k == 8) ? TB_SYS : k[2:0], 1'b0});
      run_for(240);
      rd_cnt(c);
      e = tb_exp(k);
      tol = (e == 0) ? 0 : 2;
      `CHK("count rate", 1'b1, (int'(c) >= e - tol) && (int'(c) <= e + tol))
    end
    idle <= 1'b0;
    // Wrap sets the flag; the request waits for both enables.
    wr_reg(OFF_MODE, 8'h09);
    wr_reg(OFF_IRQ_EN, 8'h01);
    set_cnt(16'hfff0);
    wr_reg(OFF_CTRL, 8'h40);
    repeat (30) @(posedge clk);
    #1;
    `CHK("irq gated", 1'b0, irq)
    wr_reg(OFF_IRQ_EN, 8'h03);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq ovf", 1'b1, irq)
    rd_reg(OFF_CTRL, d);
    `CHK("ovf sticky", 8'hc0, d)
    wr_reg(OFF_CTRL, 8'h40);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq cleared", 1'b0, irq)
    wr_reg(OFF_CTRL, 8'h00);
    // A wrap inside a read-modify-write of the control register is lost.
    set_cnt(16'hfff0);
    rmw <= 1'b1;
    run_for(40);
    rmw <= 1'b0;
    `CHK("ovf masked", 1'b0, ctl[7])
    // Software restores the lost wrap by setting the flag itself.
    wr_reg(OFF_CTRL, 8'h80);
    rd_reg(OFF_CTRL, d);
    `CHK("ovf by write", 8'h80, d)
    wr_reg(OFF_CTRL, 8'h00);
    wr_reg(OFF_MODE, 8'h00);
    // Capture on each edge choice, each module once.
    for (int m = 0; m < 6; m++) begin
      cm = capt[m % 3];
      seed = lfsr(seed);
      set_cnt(seed[15:0]);
      wr_reg(OFF_MMODE_BASE + m[7:0], cm | 8'h01);
      line_req[m] <= 1'b1;
      repeat (10) @(posedge clk);
      rd_reg(OFF_CTRL, d);
      `CHK("rise flag", cm[MM_RISE], d[m])
      `CHK("capture irq", cm[MM_RISE], irq)
      rd_reg(OFF_VLO_BASE + m[7:0], lo);
      rd_reg(OFF_VHI_BASE + m[7:0], hi);
      `CHK("capture value", cm[MM_RISE] ? seed[15:0] : 16'h0000, {hi, lo})
      wr_reg(OFF_CTRL, 8'h00);
      line_req[m] <= 1'b0;
      repeat (10) @(posedge clk);
      rd_reg(OFF_CTRL, d);
      `CHK("fall flag", cm[MM_FALL], d[m])
      wr_reg(OFF_CTRL, 8'h00);
      wr_reg(OFF_MMODE_BASE + m[7:0], 8'h00);
    end
    // All compare modes side by side from count zero.
    wr_reg(OFF_IRQ_EN, 8'h00);
    set_cnt(16'h0000);
    for (int m = 0; m < 6; m++) begin
      wr_reg(OFF_VLO_BASE + m[7:0], vl[m]);
      wr_reg(OFF_VHI_BASE + m[7:0], vh[m]);
      wr_reg(OFF_MMODE_BASE + m[7:0], mm[m]);
    end
    wr_reg(OFF_MODE, {4'h0, TB_SYS, 1'b0});
    run_for(144);
    chk_out(1'b1);
    run_for(256);
    chk_out(1'b0);
    end_sim();
  end
endmodule
